// ### logic/tcdac_pkg.sv
// Purpose: shared constants for the temperature-indexed converter serial slave
// Assumes: 40 MHz REF_CLK, two-wire bus sampled as plain inputs
// Notes:   map offsets, timing counts and reset values live here
// Contract
// - low temp byte: fraction in upper nibble
// - pointer selects entry copied to settings
// - two user byte ranges, plain storage
// - setting bytes drive converters, user writable
// - table base is -40C, 4C per entry
// - convert from power-up, refresh every 10ms
// - no conversion during serial memory access
// - 4C boundaries with 1C hysteresis
// - start and stop detected while clock high
// - idle standby after power-on, stop, write
// - acknowledge each received address/data byte; a ninth data byte in one page is not acked
// - address 1010000 plus direction bit
// - write then timed commit after stop
// - page up to eight bytes, commit on stop
// - no address ack while write busy
// - address register increments and wraps
// - sequential read continues while acked, wraps
// - table select 01h/02h picks table
// - sensor update off gives manual mode
// - pointer update off allows direct pointer load
package tcdac_pkg;
	// ==========================================================
	// memory map
	localparam logic [7:0] TABLE_SELECT_ADDR  = 8'h60;
	localparam logic [7:0] CONFIG_ADDR        = 8'h61;
	localparam logic [7:0] TEMP_HIGH_ADDR     = 8'h62;
	localparam logic [7:0] TEMP_LOW_ADDR      = 8'h63;
	localparam logic [7:0] POINTER_ADDR       = 8'h64;
	localparam logic [7:0] SUPPLY_SET_ADDR    = 8'h70;
	localparam logic [7:0] GROUND_SET_ADDR    = 8'h71;
	localparam logic [7:0] TABLE_BASE_ADDR    = 8'h80;
	localparam logic [7:0] TABLE_LAST_ADDR    = 8'hA7;
	localparam logic [7:0] TABLE_ONE          = 8'h01;
	localparam logic [7:0] TABLE_TWO          = 8'h02;
	// ==========================================================
	// config fields and reset values
	localparam int         CFG_POINTER_BIT    = 0;
	localparam int         CFG_SENSOR_BIT     = 1;
	localparam int         CFG_DONE_BIT       = 2;
	localparam logic [7:0] CONFIG_RESET       = 8'h0F;
	localparam logic [7:0] TABLE_SELECT_RESET = 8'h01;
	localparam logic [6:0] DEVICE_ADDR        = 7'h50;
	// ==========================================================
	// temperature steps (whole degrees)
	localparam int         TABLE_ENTRIES      = 40;
	localparam logic signed [7:0] TEMP_BASE   = -8'sd40;
	localparam int         TEMP_STEP_SHIFT    = 2;
	localparam logic signed [7:0] HYSTERESIS  = 8'sd1;
	// ==========================================================
	// timing
	localparam int         CLK_HZ             = 40_000_000;
	localparam int         CONV_PERIOD_MS     = 10;
	localparam int         CONV_CYCLES        = CLK_HZ / 1000 * CONV_PERIOD_MS;
	localparam int         WRITE_TIME_MS      = 10;
	localparam int         WRITE_CYCLES       = CLK_HZ / 1000 * WRITE_TIME_MS;
	localparam int         PAGE_BYTES         = 8;
endpackage

// ### logic/tcdac_bus_edges.sv
// Purpose: synchronise bus pins and find clock edges, start and stop
// Assumes: pins asynchronous to REF_CLK
// Notes:   all outputs one-cycle pulses except the levels
`timescale 1ns/1ps
module tcdac_bus_edges
	import tcdac_pkg::*;
(
	input  wire logic REF_CLK,
	input  wire logic RST_B,
	input  wire logic SCL,
	input  wire logic SDA,
	output logic      SDA_LEVEL,
	output logic      SCL_RISE,
	output logic      SCL_FALL,
	output logic      START_SEEN,
	output logic      STOP_SEEN
);
	// ==========================================================
	// three-stage synchronisers, then one history stage
	logic [1:0] scl_meta;    // stage one read only by stage two
	logic [1:0] sda_meta;
	logic       scl_s;       // synchronised levels
	logic       sda_s;
	logic       scl_d;       // previous synchronised levels
	logic       sda_d;
	logic       next_scl_rise;
	logic       next_scl_fall;
	logic       next_start;
	logic       next_stop;

	// edge and condition decode on synchronised levels only
	always_comb begin
		next_scl_rise = scl_s & ~scl_d;
		next_scl_fall = ~scl_s & scl_d;
		next_start    = scl_s & scl_d & sda_d & ~sda_s;
		next_stop     = scl_s & scl_d & ~sda_d & sda_s;
	end

	// registers only; idle bus is high
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			scl_meta   <= 2'h3;
			sda_meta   <= 2'h3;
			scl_s      <= 1'b1;
			sda_s      <= 1'b1;
			scl_d      <= 1'b1;
			sda_d      <= 1'b1;
			SDA_LEVEL  <= 1'b1;
			SCL_RISE   <= 1'b0;
			SCL_FALL   <= 1'b0;
			START_SEEN <= 1'b0;
			STOP_SEEN  <= 1'b0;
		end else begin
			scl_meta   <= {scl_meta[0], SCL};
			sda_meta   <= {sda_meta[0], SDA};
			scl_s      <= scl_meta[1];
			sda_s      <= sda_meta[1];
			scl_d      <= scl_s;
			sda_d      <= sda_s;
			SDA_LEVEL  <= sda_s;
			SCL_RISE   <= next_scl_rise;
			SCL_FALL   <= next_scl_fall;
			START_SEEN <= next_start;
			STOP_SEEN  <= next_stop;
		end
	end
endmodule

// ### logic/tcdac_serial_slave.sv
// Purpose: two-wire slave with byte map, lookup tables and converter settings
// Assumes: sensor result arrives as a signed whole/fraction word on TEMP_IN
// Notes:   nonvolatile commit is modelled by a timed busy window
`timescale 1ns/1ps
module tcdac_serial_slave
	import tcdac_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	input  wire logic        SCL,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE,
	input  wire logic [11:0] TEMP_IN,
	output logic [7:0]       SUPPLY_REF_OUTPUT,
	output logic [7:0]       GROUND_REF_OUTPUT,
	output logic             STANDBY
);
	// ==========================================================
	// bus edge finder
	logic sda_level;   // synchronised data
	logic scl_rise;    // sample point
	logic scl_fall;    // drive point
	logic start_seen;  // start or repeated start
	logic stop_seen;   // stop

	tcdac_bus_edges edges (
		.REF_CLK    (REF_CLK),
		.RST_B      (RST_B),
		.SCL        (SCL),
		.SDA        (SDA_IN),
		.SDA_LEVEL  (sda_level),
		.SCL_RISE   (scl_rise),
		.SCL_FALL   (scl_fall),
		.START_SEEN (start_seen),
		.STOP_SEEN  (stop_seen)
	);

	// ==========================================================
	// protocol state
	typedef enum logic [2:0] {
		ST_IDLE, ST_DEVADDR, ST_MEMADDR, ST_WDATA, ST_RDATA, ST_ACK, ST_MACK
	} phase_e;

	phase_e     phase, next_phase;
	phase_e     after_ack, next_after_ack; // phase after our ack bit
	logic [3:0] bit_cnt, next_bit_cnt;     // bits of current byte
	logic [7:0] shift, next_shift;         // receive/transmit shift
	logic [7:0] addr, next_addr;           // internal address register
	logic       ack_drive, next_ack_drive; // pulling data low
	logic       reading, next_reading;     // transmitter mode
	logic [3:0] page_cnt, next_page_cnt;   // bytes staged this page
	logic       dirty, next_dirty;         // commit needed at stop
	logic [31:0] busy_cnt, next_busy_cnt;  // nonvolatile write timer

	// ==========================================================
	// storage: general bytes 60h-7Fh and two 40-entry tables
	logic [7:0] low_mem [0:31];
	logic [7:0] next_low_mem [0:31];
	logic [7:0] tbl [0:1][0:TABLE_ENTRIES-1];
	logic [7:0] next_tbl [0:1][0:TABLE_ENTRIES-1];
	logic [7:0] temp_high, next_temp_high;  // whole degrees
	logic [7:0] temp_low, next_temp_low;    // fraction nibble
	logic [31:0] conv_cnt, next_conv_cnt;   // conversion period timer
	logic        busy;

	assign busy = (busy_cnt != 32'h0);

	// read mux over whole byte space
	function automatic logic [7:0] read_byte(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a >= TABLE_SELECT_ADDR && a < TABLE_BASE_ADDR) begin
			r = low_mem[a[4:0]];
			if (a == TEMP_HIGH_ADDR) r = temp_high;
			if (a == TEMP_LOW_ADDR) r = temp_low;
		end else if (a >= TABLE_BASE_ADDR && a <= TABLE_LAST_ADDR) begin
			r = tbl[low_mem[0] == TABLE_TWO][6'(a - TABLE_BASE_ADDR)];
		end
		return r;
	endfunction

	// ==========================================================
	// serial protocol and memory writes
	always_comb begin
		logic [7:0] rx;
		logic [7:0] ptr_idx;
		logic signed [7:0] whole;
		logic signed [7:0] cur_lo;
		rx             = {shift[6:0], sda_level};
		ptr_idx        = 8'h00;
		whole          = 8'sh00;
		cur_lo         = 8'sh00;
		next_phase     = phase;
		next_after_ack = after_ack;
		next_bit_cnt   = bit_cnt;
		next_shift     = shift;
		next_addr      = addr;
		next_ack_drive = ack_drive;
		next_reading   = reading;
		next_page_cnt  = page_cnt;
		next_dirty     = dirty;
		next_busy_cnt  = busy ? busy_cnt - 32'h1 : busy_cnt;
		next_low_mem   = low_mem;
		next_tbl       = tbl;
		next_temp_high = temp_high;
		next_temp_low  = temp_low;
		next_conv_cnt  = conv_cnt;

		if (stop_seen) begin
			next_phase     = ST_IDLE;
			next_ack_drive = 1'b0;
			if (dirty) next_busy_cnt = 32'(WRITE_CYCLES);
			next_dirty     = 1'b0;
		end else if (start_seen) begin
			// a start without stop cancels the commit; staged page bytes stay in storage
			next_phase     = busy ? ST_IDLE : ST_DEVADDR;
			next_bit_cnt   = 4'h0;
			next_ack_drive = 1'b0;
			next_dirty     = 1'b0;
		end else if (phase != ST_IDLE && scl_rise) begin
			case (phase)
				ST_DEVADDR, ST_MEMADDR, ST_WDATA: begin
					next_shift   = rx;
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == 4'h7) begin
						next_bit_cnt = 4'h0;
						next_phase   = ST_ACK;
						if (phase == ST_DEVADDR) begin
							if (rx[7:1] != DEVICE_ADDR || busy)
								next_phase = ST_IDLE;
							next_reading   = rx[0];
							next_after_ack = rx[0] ? ST_RDATA : ST_MEMADDR;
							next_page_cnt  = 4'h0;
						end else if (phase == ST_MEMADDR) begin
							next_addr      = rx;
							next_after_ack = ST_WDATA;
						end else begin
							next_after_ack = ST_WDATA;
							if (page_cnt == 4'(PAGE_BYTES)) begin
								next_phase = ST_IDLE; // page overflow not acked
							end else begin
								next_page_cnt = page_cnt + 4'h1;
								next_dirty    = 1'b1;
								if (addr >= TABLE_SELECT_ADDR && addr < TABLE_BASE_ADDR) begin
									if (addr != TEMP_HIGH_ADDR && addr != TEMP_LOW_ADDR)
										next_low_mem[addr[4:0]] = rx;
								end else if (addr >= TABLE_BASE_ADDR && addr <= TABLE_LAST_ADDR) begin
									next_tbl[low_mem[0] == TABLE_TWO][6'(addr - TABLE_BASE_ADDR)] = rx;
								end
								next_addr = addr + 8'h01;
							end
						end
					end
				end
				ST_RDATA: begin
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == 4'h7) begin
						next_bit_cnt = 4'h0;
						next_phase   = ST_MACK;
						next_addr    = addr + 8'h01;
					end
				end
				ST_MACK: begin
					// master ack keeps streaming, nack releases bus
					next_phase = sda_level ? ST_IDLE : ST_RDATA;
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			case (phase)
				ST_ACK: begin
					if (!ack_drive) begin
						next_ack_drive = 1'b1;
					end else begin
						next_ack_drive = 1'b0;
						next_phase     = after_ack;
						if (after_ack == ST_RDATA) next_shift = read_byte(addr);
					end
				end
				ST_RDATA: begin
					if (bit_cnt != 4'h0) next_shift = {shift[6:0], 1'b0};
				end
				ST_MACK: begin
					next_shift = read_byte(addr);
				end
				default: ;
			endcase
		end

		// periodic conversion, held off during any serial access
		if (phase == ST_IDLE && !busy && low_mem[CONFIG_ADDR[4:0]][CFG_SENSOR_BIT]) begin
			next_conv_cnt = conv_cnt + 32'h1;
			if (conv_cnt >= 32'(CONV_CYCLES - 1)) begin
				next_conv_cnt  = 32'h0;
				next_temp_high = TEMP_IN[11:4];
				next_temp_low  = {TEMP_IN[3:0], 4'h0};
				whole          = $signed(TEMP_IN[11:4]);
				// entry offset times four is held in ten bits, and the sum stays in eight-bit range
				cur_lo         = 8'(TEMP_BASE + $signed({low_mem[POINTER_ADDR[4:0]] - TABLE_BASE_ADDR, 2'b00}));
				if (low_mem[CONFIG_ADDR[4:0]][CFG_POINTER_BIT]) begin
					ptr_idx = low_mem[POINTER_ADDR[4:0]];
					// step up at boundary, step down one degree below it
					if (whole >= cur_lo + 8'sd4 && ptr_idx < TABLE_LAST_ADDR)
						ptr_idx = ptr_idx + 8'h01;
					else if (whole < cur_lo - HYSTERESIS && ptr_idx > TABLE_BASE_ADDR)
						ptr_idx = ptr_idx - 8'h01;
					if (ptr_idx < TABLE_BASE_ADDR || ptr_idx > TABLE_LAST_ADDR)
						ptr_idx = TABLE_BASE_ADDR;
					next_low_mem[POINTER_ADDR[4:0]] = ptr_idx;
					next_low_mem[CONFIG_ADDR[4:0]][CFG_DONE_BIT] = 1'b1;
				end
			end
		end

		// settings follow pointed entry unless in manual mode
		if (low_mem[CONFIG_ADDR[4:0]][CFG_SENSOR_BIT] || !low_mem[CONFIG_ADDR[4:0]][CFG_POINTER_BIT]) begin
			ptr_idx = next_low_mem[POINTER_ADDR[4:0]];
			if (ptr_idx >= TABLE_BASE_ADDR && ptr_idx <= TABLE_LAST_ADDR && low_mem[CONFIG_ADDR[4:0]][CFG_SENSOR_BIT]) begin
				next_low_mem[SUPPLY_SET_ADDR[4:0]] = tbl[0][6'(ptr_idx - TABLE_BASE_ADDR)];
				next_low_mem[GROUND_SET_ADDR[4:0]] = tbl[1][6'(ptr_idx - TABLE_BASE_ADDR)];
			end
		end
	end

	// ==========================================================
	// state registers
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			phase     <= ST_IDLE;
			after_ack <= ST_IDLE;
			bit_cnt   <= 4'h0;
			shift     <= 8'h00;
			addr      <= 8'h00;
			ack_drive <= 1'b0;
			reading   <= 1'b0;
			page_cnt  <= 4'h0;
			dirty     <= 1'b0;
			busy_cnt  <= 32'h0;
			temp_high <= 8'h00;
			temp_low  <= 8'h00;
			conv_cnt  <= 32'h0;
			for (int i = 0; i < 32; i++) low_mem[i] <= 8'h00;
			low_mem[0]                  <= TABLE_SELECT_RESET;
			low_mem[CONFIG_ADDR[4:0]]   <= CONFIG_RESET;
			low_mem[POINTER_ADDR[4:0]]  <= TABLE_BASE_ADDR;
			for (int t = 0; t < 2; t++)
				for (int i = 0; i < TABLE_ENTRIES; i++) tbl[t][i] <= 8'h00;
		end else begin
			phase     <= next_phase;
			after_ack <= next_after_ack;
			bit_cnt   <= next_bit_cnt;
			shift     <= next_shift;
			addr      <= next_addr;
			ack_drive <= next_ack_drive;
			reading   <= next_reading;
			page_cnt  <= next_page_cnt;
			dirty     <= next_dirty;
			busy_cnt  <= next_busy_cnt;
			temp_high <= next_temp_high;
			temp_low  <= next_temp_low;
			conv_cnt  <= next_conv_cnt;
			low_mem   <= next_low_mem;
			tbl       <= next_tbl;
		end
	end

	// ==========================================================
	// pin and converter outputs, registered
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			SDA_OUT           <= 1'b0;
			SDA_OE            <= 1'b0;
			SUPPLY_REF_OUTPUT <= 8'h00;
			GROUND_REF_OUTPUT <= 8'h00;
			STANDBY           <= 1'b1;
		end else begin
			SDA_OUT           <= 1'b0; // open drain: only ever pulls low
			SDA_OE            <= next_ack_drive | (next_phase == ST_RDATA && !next_shift[7]);
			SUPPLY_REF_OUTPUT <= next_low_mem[SUPPLY_SET_ADDR[4:0]];
			GROUND_REF_OUTPUT <= next_low_mem[GROUND_SET_ADDR[4:0]];
			STANDBY           <= (next_phase == ST_IDLE) && (next_busy_cnt == 32'h0);
		end
	end
endmodule

// ### verification/tcdac_properties.sv
// Purpose: port-level checks for the two-wire converter slave
// Assumes: SDA_IN is the wired bus level, SCL from an outside master
// Notes:   one clock domain, so default clocking and disable
`timescale 1ns/1ps
module tcdac_checker (
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	input wire logic        SCL,
	input wire logic        SDA_IN,
	input wire logic        SDA_OUT,
	input wire logic        SDA_OE,
	input wire logic [11:0] TEMP_IN,
	input wire logic [7:0]  SUPPLY_REF_OUTPUT,
	input wire logic [7:0]  GROUND_REF_OUTPUT,
	input wire logic        STANDBY
);
	// ==========================================
	// bus conditions seen at the pins
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	// data falls while clock high
	sequence start_cond;
		SCL && $fell(SDA_IN);
	endsequence
	// data rises while clock high
	sequence stop_cond;
		SCL && $rose(SDA_IN);
	endsequence
	// ==========================================
	// assertions
	a_sda_out_zero: assert property (SDA_OUT == 1'b0)
		else $error("data output not held low");
	a_reset_idle: assert property ($rose(RST_B) |-> STANDBY && !SDA_OE)
		else $error("not idle after reset");
	a_reset_outputs: assert property ($rose(RST_B) |-> SUPPLY_REF_OUTPUT == 8'h00 && GROUND_REF_OUTPUT == 8'h00)
		else $error("settings not cleared by reset");
	a_standby_quiet: assert property (STANDBY |-> !SDA_OE)
		else $error("bus driven in standby");
	a_start_wakes: assert property (start_cond |-> ##[1:8] !STANDBY)
		else $error("start left device in standby");
	a_stop_release: assert property (stop_cond |=> (!SDA_OE) [*4])
		else $error("bus driven after stop");
	a_ack_hold: assert property (SDA_OE && SCL |=> SDA_OE)
		else $error("drive dropped while clock high");
	a_drive_low_phase: assert property ($rose(SDA_OE) |-> !$past(SCL, 2))
		else $error("drive started in clock high phase");
	// settings hold steady while the slave drives the data line
	a_settings_frozen: assert property (SDA_OE |-> $stable(SUPPLY_REF_OUTPUT) && $stable(GROUND_REF_OUTPUT))
		else $error("settings moved during transfer");
endmodule

bind tcdac_serial_slave tcdac_checker chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .SCL(SCL), .SDA_IN(SDA_IN),
	.SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .TEMP_IN(TEMP_IN), .SUPPLY_REF_OUTPUT(SUPPLY_REF_OUTPUT),
	.GROUND_REF_OUTPUT(GROUND_REF_OUTPUT), .STANDBY(STANDBY));

// ### verification/bus_master_model.sv
// Purpose: two-wire master driving the link clock
// Assumes: 200 ns bit, open-drain data with pull-up
// Notes:   clock stands high between frames
`timescale 1ns/1ps
module bus_master_model (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	// ==========================================
	// lines released at time zero
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// one bit: low 125 ns, high 75 ns, sampled at the end of high
	task automatic bit_cycle(input logic b, output logic seen);
		scl = 1'b0;
		#60 sda_drv = b;
		#65 scl = 1'b1;
		#75 seen = sda;
	endtask
	// start, also usable as a repeated start
	task automatic start();
		scl = 1'b0;
		#60 sda_drv = 1'b1;
		#65 scl = 1'b1;
		#50 sda_drv = 1'b0;
		#50;
	endtask
	task automatic stop();
		scl = 1'b0;
		#60 sda_drv = 1'b0;
		#65 scl = 1'b1;
		#50 sda_drv = 1'b1;
		#50;
	endtask
	// clear a half-finished frame in the slave
	task automatic recover();
		logic s;
		repeat (9) bit_cycle(1'b1, s);
	endtask
	// byte out msb first, ack returned
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
		bit_cycle(1'b1, s);
		ack = !s;
	endtask
	// byte in, then our own ack or nack
	task automatic get_byte(input logic ack_it, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
		bit_cycle(!ack_it, s);
	endtask
endmodule

// ### verification/temp_indexed_dac_serial_slave_bench.sv
// Purpose: self-checking bench for the converter serial slave
// Assumes: write commit outlasts the run, so stored data is not read back
// Notes:   reset-value reads as rows, protocol cases by hand
`timescale 1ns/1ps
module temp_indexed_dac_serial_slave_bench;
	typedef struct {logic [7:0] addr; logic [7:0] exp;} row_s;
	logic        ref_clk;
	logic        rst_b;
	logic [11:0] temp_in;
	logic        sda_oe;
	logic        standby;
	logic        sda_out;    // open-drain data level, always low
	logic [7:0]  supply_out; // converter setting outputs
	logic [7:0]  ground_out;
	logic [7:0]  d;
	logic        k;
	wire         scl;
	wire         sda_drv;
	wire         sda = sda_drv & ~sda_oe; // pull-up wired-and
	int          mismatches = 0;
	int          total_checks = 0;
	// map address and its value after reset
	row_s rows [8] = '{'{8'h60, 8'h01}, '{8'h61, 8'h0F}, '{8'h63, 8'h00}, '{8'h64, 8'h80},
		'{8'h65, 8'h00}, '{8'h7F, 8'h00}, '{8'h70, 8'h00}, '{8'h71, 8'h00}};
	// ==========================================
	// design and far-side master
	tcdac_serial_slave uut (.REF_CLK(ref_clk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .TEMP_IN(temp_in), .SUPPLY_REF_OUTPUT(supply_out), .GROUND_REF_OUTPUT(ground_out),
		.STANDBY(standby));
	bus_master_model bfm (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// ==========================================
	// shared tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// dummy write that loads the address register
	task automatic point(input logic [7:0] a);
		bfm.start();
		bfm.put_byte(8'hA0, k);
		check("write addr ack", {7'h00, k}, 8'h01);
		bfm.put_byte(a, k);
		check("mem addr ack", {7'h00, k}, 8'h01);
	endtask
	task automatic begin_read();
		bfm.start();
		bfm.put_byte(8'hA1, k);
		check("read addr ack", {7'h00, k}, 8'h01);
	endtask
	// watchdog, about three times the expected run
	initial begin
		#500_000;
		mismatches++;
		end_sim();
	end
	// ==========================================
	// main sequence
	initial begin
		rst_b <= 1'b0;
		temp_in <= 12'hD80; // -40.0 degrees, the table base
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 check("standby", {7'h00, standby}, 8'h01);
		check("oe", {7'h00, sda_oe}, 8'h00);
		bfm.recover();
		$display("test reset done");
		// random reads of reset contents
		foreach (rows[i]) begin
			point(rows[i].addr);
			begin_read();
			bfm.get_byte(1'b0, d);
			bfm.stop();
			check("map byte", d, rows[i].exp);
		end
		$display("test rows done");
		// sequential read, then current read continues
		point(8'h63);
		begin_read();
		bfm.get_byte(1'b1, d);
		check("seq 63h", d, 8'h00);
		bfm.get_byte(1'b0, d);
		check("seq 64h", d, 8'h80);
		bfm.stop();
		begin_read();
		bfm.get_byte(1'b0, d);
		bfm.stop();
		check("current 65h", d, 8'h00);
		$display("test sequential done");
		// foreign device address is ignored
		bfm.start();
		bfm.put_byte(8'hA2, k);
		bfm.stop();
		check("foreign ack", {7'h00, k}, 8'h00);
		$display("test foreign done");
		// staged writes read back behind a repeated start, so no commit timer starts
		point(8'h66);
		bfm.put_byte(8'h5A, k);
		check("user write ack", {7'h00, k}, 8'h01);
		point(8'h66);
		begin_read();
		bfm.get_byte(1'b0, d);
		check("user byte", d, 8'h5A);
		point(8'h63);
		bfm.put_byte(8'h77, k);
		check("temp write ack", {7'h00, k}, 8'h01);
		point(8'h63);
		begin_read();
		bfm.get_byte(1'b0, d);
		check("temp byte kept", d, 8'h00);
		// first table entry in each table drives its converter
		point(8'h80);
		bfm.put_byte(8'hA5, k);
		point(8'h60);
		bfm.put_byte(8'h02, k);
		point(8'h80);
		bfm.put_byte(8'h3C, k);
		point(8'h80);
		begin_read();
		bfm.get_byte(1'b0, d);
		bfm.stop();
		check("second table", d, 8'h3C);
		check("supply out", supply_out, 8'hA5);
		check("ground out", ground_out, 8'h3C);
		check("data out", {7'h00, sda_out}, 8'h00);
		$display("test write readback done");
		// page of nine: eight taken, ninth refused
		point(8'h65);
		for (int i = 0; i < 9; i++) begin
			bfm.put_byte(8'hC0 + 8'(i), k);
			check("page ack", {7'h00, k}, {7'h00, i < 8});
		end
		bfm.stop();
		repeat (8) @(posedge ref_clk);
		#1 check("busy standby", {7'h00, standby}, 8'h00);
		bfm.start();
		bfm.put_byte(8'hA0, k);
		bfm.stop();
		check("poll ack", {7'h00, k}, 8'h00);
		$display("test page done");
		end_sim();
	end
endmodule
